// ===== design/i2cp_slave.sv
// i2cp_slave: two-wire serial target giving a host access to paged registers.
// assumes open-drain wiring outside and a core clock unrelated to the bus clock.
// Notes on behaviour
// [R01] answer only slave address 0011000
// [R02] target only, never drives the clock
// [R03] lines only pulled low, released otherwise
// [R04] eight-bit units, data sampled with clock high
// [R05] data fall/rise with clock high: START/STOP
// [R06] master sends 7-bit address plus direction
// [R07] acknowledge each received byte on ninth clock
// [R08] master acknowledges each byte it reads
// [R09] line left high means not-acknowledge
// [R10] master makes every clock pulse
// [R11] drive data on reads, release on writes
// [R12] STOP idles, repeated START restarts addressing
// [R13] general call acknowledged only when enabled
// [R14] write bytes go to next higher register
// [R15] acknowledged read sends next higher register
// [R16] writable registers read back, status read-only
// [R17] pages hold up to 128 registers
// [R18] page 0 selected after reset
// [R19] writing register 0 changes active page
// [R20] host touches only implemented pages
// [R21] host writes reset values to reserved bits
// [R22] registers eight bits, bit 7 first
// [R23] page register resets to zero
// [R24] first write byte is register pointer
`timescale 1ns/1ps
`include "i2cp_regs.svh"

module i2cp_slave (
    input  wire logic                       ref_clk,
    input  wire logic                       rst_n,
    input  wire logic                       scl,
    input  wire logic                       sda_in,
    output logic                            sda_out,
    output logic                            sda_oe,
    input  wire i2cp_pkg::i2cp_byte_type    stat_flags,
    output logic                            cfg_wr_stb,
    output i2cp_pkg::i2cp_byte_type         cfg_page,
    output i2cp_pkg::i2cp_reg_idx_type      cfg_reg,
    output i2cp_pkg::i2cp_byte_type         cfg_data,
    output logic                            gc_enable
);
    import i2cp_pkg::*;

    // ----------------------------------------------------------------
    // bus condition detection
    // ----------------------------------------------------------------
    logic           start_tgl_r;
    logic           stop_tgl_r;
    logic           start_seen_r;
    logic           stop_seen_r;

    // [R05] start: data falls while clock high
    always_ff @(negedge sda_in or negedge rst_n) begin
        if (!rst_n) begin
            start_tgl_r <= 1'b0;
        end else if (scl) begin
            start_tgl_r <= ~start_tgl_r;
        end
    end

    // [R05] stop: data rises while clock high
    always_ff @(posedge sda_in or negedge rst_n) begin
        if (!rst_n) begin
            stop_tgl_r <= 1'b0;
        end else if (scl) begin
            stop_tgl_r <= ~stop_tgl_r;
        end
    end

    // toggles settle while clock is high, long before the next rising edge
    wire logic start_pend = start_tgl_r ^ start_seen_r;
    wire logic stop_pend  = stop_tgl_r ^ stop_seen_r;

    // ----------------------------------------------------------------
    // serial clock domain state
    // ----------------------------------------------------------------
    i2cp_state_type   st_r;
    i2cp_state_type   st_nxt;
    logic [3:0]       bit_cnt_r;
    logic [3:0]       bit_nxt;
    i2cp_byte_type    shift_r;
    i2cp_reg_idx_type ptr_r;
    i2cp_reg_idx_type ptr_nxt;
    i2cp_byte_type    page_r;
    i2cp_byte_type    page_nxt;
    logic             ack_r;
    logic             ack_nxt;
    logic             rw_r;
    logic             rw_nxt;
    logic             gc_en_r;
    logic             gc_nxt;
    logic             sda_oe_r;
    i2cp_byte_type    stat_s1_r;
    i2cp_byte_type    stat_s2_r;
    i2cp_byte_type    mem_rd;

    // [R04] byte assembled msb first from clock-high samples
    wire i2cp_byte_type rx_byte   = {shift_r[6:0], sda_in};
    wire logic          byte_done = (bit_cnt_r == 4'd7);
    wire logic          ack_slot  = (bit_cnt_r == 4'd8);
    wire logic          live      = !start_pend && !stop_pend;
    // [R01] fixed slave address
    wire logic          addr_hit  = (rx_byte[7:1] == `I2CP_DEV_ADDR);
    // [R13] general call only with enable set
    wire logic          gc_hit    = (rx_byte == `I2CP_GC_ADDR) && gc_en_r;
    wire logic          page0     = (page_r == `I2CP_PAGE_HOME);
    wire logic          at_stat   = page0 && (ptr_r == `I2CP_STAT_REG);
    wire logic          at_gc     = page0 && (ptr_r == `I2CP_GC_REG);
    wire logic          at_page   = (ptr_r == `I2CP_PAGE_REG);
    wire logic          wr_fire   = (st_r == ST_WDATA) && byte_done && live;
    // [R16] status register ignores writes
    wire logic          mem_we    = wr_fire && !at_page && !at_stat;
    wire logic [2:0]    tx_idx    = 3'(3'd7 - bit_cnt_r[2:0]);

    // [R16] readback merges live flags and held bits
    wire i2cp_byte_type gc_view   = {mem_rd[7:6], gc_en_r, mem_rd[4:0]};
    wire i2cp_byte_type rd_data   = at_page ? page_r :
                                    at_stat ? stat_s2_r :
                                    at_gc   ? gc_view : mem_rd;

    always_comb begin
        st_nxt   = st_r;
        bit_nxt  = bit_cnt_r;
        ptr_nxt  = ptr_r;
        page_nxt = page_r;
        ack_nxt  = ack_r;
        rw_nxt   = rw_r;
        gc_nxt   = gc_en_r;
        if (start_pend) begin
            // [R12] repeated start restarts addressing
            st_nxt  = ST_ADDR;
            bit_nxt = 4'd1;
            ack_nxt = 1'b0;
        end else if (stop_pend || (st_r == ST_IDLE)) begin
            st_nxt  = ST_IDLE;
            bit_nxt = 4'd0;
            ack_nxt = 1'b0;
        end else if (ack_slot) begin
            bit_nxt = 4'd0;
            if (st_r == ST_RDATA) begin
                // [R09] master leaves line high: end read
                if (sda_in) begin
                    st_nxt = ST_IDLE;
                end else begin
                    // [R15] next higher register on acknowledge
                    ptr_nxt = 7'(ptr_r + 7'd1);
                end
            end else if (!ack_r) begin
                st_nxt = ST_IDLE;
            end else if (st_r == ST_ADDR) begin
                st_nxt = rw_r ? ST_RDATA : ST_PTR;
            end
        end else begin
            bit_nxt = 4'(bit_cnt_r + 4'd1);
            if (byte_done) begin
                unique case (st_r)
                    ST_IDLE: begin
                    end
                    ST_ADDR: begin
                        ack_nxt = addr_hit || gc_hit;
                        rw_nxt  = rx_byte[0] && addr_hit;
                    end
                    ST_PTR: begin
                        // [R24] first byte is register pointer
                        ptr_nxt = rx_byte[6:0];
                        ack_nxt = 1'b1;
                        st_nxt  = ST_WDATA;
                    end
                    ST_WDATA: begin
                        ack_nxt = 1'b1;
                        // [R14] auto-increment on write
                        ptr_nxt = 7'(ptr_r + 7'd1);
                        // [R19] register 0 selects the page
                        if (at_page) begin
                            page_nxt = rx_byte;
                        end
                        if (at_gc) begin
                            gc_nxt = rx_byte[`I2CP_GC_BIT];
                        end
                    end
                    ST_RDATA: begin
                        ack_nxt = 1'b0;
                    end
                endcase
            end
        end
    end

    // [R02] logic only follows the master's clock
    always_ff @(posedge scl or negedge rst_n) begin
        if (!rst_n) begin
            st_r         <= ST_IDLE;
            bit_cnt_r    <= 4'd0;
            shift_r      <= 8'h00;
            ptr_r        <= 7'h00;
            ack_r        <= 1'b0;
            rw_r         <= 1'b0;
            start_seen_r <= 1'b0;
            stop_seen_r  <= 1'b0;
        end else begin
            st_r         <= st_nxt;
            bit_cnt_r    <= bit_nxt;
            shift_r      <= rx_byte;
            ptr_r        <= ptr_nxt;
            ack_r        <= ack_nxt;
            rw_r         <= rw_nxt;
            start_seen_r <= start_tgl_r;
            stop_seen_r  <= stop_tgl_r;
        end
    end

    // [R18] [R23] page register and enable reset values
    always_ff @(posedge scl or negedge rst_n) begin
        if (!rst_n) begin
            page_r  <= `I2CP_PAGE_RST;
            gc_en_r <= `I2CP_GC_RST;
        end else begin
            page_r  <= page_nxt;
            gc_en_r <= gc_nxt;
        end
    end

    // status flags from the core, two flops on the bus clock
    always_ff @(posedge scl or negedge rst_n) begin
        if (!rst_n) begin
            stat_s1_r <= 8'h00;
            stat_s2_r <= 8'h00;
        end else begin
            stat_s1_r <= stat_flags;
            stat_s2_r <= stat_s1_r;
        end
    end

    // ----------------------------------------------------------------
    // data line drive, changed only while clock is low
    // ----------------------------------------------------------------
    // [R07] [R11] ack in slot, read bits otherwise
    wire logic drive_nxt = ack_slot ? ack_r :
                           ((st_r == ST_RDATA) && !bit_cnt_r[3]) ? ~rd_data[tx_idx] : 1'b0;

    always_ff @(negedge scl or negedge rst_n) begin
        if (!rst_n) begin
            sda_oe_r <= 1'b0;
        end else begin
            sda_oe_r <= drive_nxt;
        end
    end

    // [R03] open drain: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe  = sda_oe_r;

    i2cp_regfile #(
        .BANKS (7),
        .REGS  (128)
    ) u_regs (
        .clk     (scl),
        .wr_en   (mem_we),
        .wr_page (page_r),
        .wr_reg  (ptr_r),
        .wr_data (rx_byte),
        .rd_page (page_r),
        .rd_reg  (ptr_r),
        .rd_data    (mem_rd),
        .rst_n      (rst_n),
        .evt_en     (wr_fire),
        .gc_en      (gc_en_r),
        .ref_clk    (ref_clk),
        .cfg_wr_stb (cfg_wr_stb),
        .cfg_page   (cfg_page),
        .cfg_reg    (cfg_reg),
        .cfg_data   (cfg_data),
        .gc_enable  (gc_enable)
    );

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_addr_byte;
        (st_r == ST_ADDR) && byte_done && live;
    endsequence

    sequence s_rd_ack;
        (st_r == ST_RDATA) && ack_slot && !sda_in && live;
    endsequence

    chk_addr_ack: assert property (@(posedge scl) disable iff (!rst_n) // [R01]
        s_addr_byte ##0 addr_hit |=> ack_r && ack_slot)
        else $error("own address not acknowledged");

    chk_gc_gate: assert property (@(posedge scl) disable iff (!rst_n) // [R13]
        s_addr_byte ##0 (rx_byte == 8'h00) && !gc_en_r |=> !ack_r)
        else $error("general call acknowledged while disabled");

    chk_ack_drive: assert property (@(posedge scl) disable iff (!rst_n) // [R07]
        ack_slot && ack_r && live |-> sda_oe)
        else $error("acknowledge not driven in ninth clock");

    chk_tx_bit: assert property (@(posedge scl) disable iff (!rst_n) // [R11]
        (st_r == ST_RDATA) && !bit_cnt_r[3] && live |-> sda_oe == ~rd_data[tx_idx])
        else $error("read bit not on data line");

    chk_write_inc: assert property (@(posedge scl) disable iff (!rst_n) // [R14]
        wr_fire |=> ptr_r == 7'($past(ptr_r) + 7'd1))
        else $error("write pointer did not advance");

    chk_read_inc: assert property (@(posedge scl) disable iff (!rst_n) // [R15]
        s_rd_ack |=> (ptr_r == 7'($past(ptr_r) + 7'd1)) && (st_r == ST_RDATA))
        else $error("read pointer did not advance");

    chk_page_sel: assert property (@(posedge scl) disable iff (!rst_n) // [R19]
        wr_fire && at_page |=> page_r == $past(rx_byte))
        else $error("page register write lost");

    chk_nack_release: assert property (@(posedge scl) disable iff (!rst_n) // [R09]
        (st_r == ST_RDATA) && ack_slot && sda_in && live |=> (st_r == ST_IDLE) && !sda_oe)
        else $error("read not ended after not-acknowledge");

    chk_restart: assert property (@(posedge scl) disable iff (!rst_n) // [R12]
        start_pend |=> (st_r == ST_ADDR) && (bit_cnt_r == 4'd1))
        else $error("start did not restart addressing");

endmodule // i2cp_slave

// ===== design/i2cp_regs.svh
// i2cp_regs.svh: constants of the paged two-wire register slave.
// assumes inclusion by bare name from the design files.
`ifndef I2CP_REGS_SVH
`define I2CP_REGS_SVH

// ----------------------------------------------------------------
// bus addressing
// ----------------------------------------------------------------
`define I2CP_DEV_ADDR     7'h18
`define I2CP_GC_ADDR      8'h00

// ----------------------------------------------------------------
// register offsets and fields inside a page
// ----------------------------------------------------------------
`define I2CP_PAGE_REG     7'h00
`define I2CP_STAT_REG     7'h03
`define I2CP_GC_REG       7'h22
`define I2CP_GC_BIT       5
`define I2CP_PAGE_RST     8'h00
`define I2CP_GC_RST       1'b0

// ----------------------------------------------------------------
// implemented pages
// ----------------------------------------------------------------
`define I2CP_PAGE_HOME    8'h00
`define I2CP_PAGE_P1      8'h01
`define I2CP_PAGE_P3      8'h03
`define I2CP_PAGE_P8      8'h08
`define I2CP_PAGE_P9      8'h09
`define I2CP_PAGE_P12     8'h0C
`define I2CP_PAGE_P13     8'h0D

`endif

// ===== design/i2cp_pkg.sv
// i2cp_pkg: types of the paged two-wire register slave.
// assumes nothing beyond a SystemVerilog compiler.
package i2cp_pkg;

    typedef logic [7:0] i2cp_byte_type;
    typedef logic [6:0] i2cp_reg_idx_type;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_ADDR  = 5'b00010,
        ST_PTR   = 5'b00100,
        ST_WDATA = 5'b01000,
        ST_RDATA = 5'b10000
    } i2cp_state_type;

endpackage

// ===== design/i2cp_regfile.sv
// i2cp_regfile: paged 8-bit register storage and the core-side write bridge.
// assumes storage runs on the serial clock and the bridge ends on ref_clk.
`timescale 1ns/1ps
`include "i2cp_regs.svh"

module i2cp_regfile #(
    parameter int BANKS = 7,
    parameter int REGS  = 128
) (
    input  wire logic                       clk,
    input  wire logic                       wr_en,
    input  wire i2cp_pkg::i2cp_byte_type    wr_page,
    input  wire i2cp_pkg::i2cp_reg_idx_type wr_reg,
    input  wire i2cp_pkg::i2cp_byte_type    wr_data,
    input  wire i2cp_pkg::i2cp_byte_type    rd_page,
    input  wire i2cp_pkg::i2cp_reg_idx_type rd_reg,
    output i2cp_pkg::i2cp_byte_type         rd_data,
    input  wire logic                       rst_n,
    input  wire logic                       evt_en,
    input  wire logic                       gc_en,
    input  wire logic                       ref_clk,
    output logic                            cfg_wr_stb,
    output i2cp_pkg::i2cp_byte_type         cfg_page,
    output i2cp_pkg::i2cp_reg_idx_type      cfg_reg,
    output i2cp_pkg::i2cp_byte_type         cfg_data,
    output logic                            gc_enable
);
    import i2cp_pkg::*;

    // ----------------------------------------------------------------
    // page to bank mapping
    // ----------------------------------------------------------------
    function automatic logic [3:0] bank_of(input i2cp_byte_type page);
        logic [3:0] b;
        b = 4'hF;
        unique case (page)
            `I2CP_PAGE_HOME: b = 4'h0;
            `I2CP_PAGE_P1:   b = 4'h1;
            `I2CP_PAGE_P3:   b = 4'h2;
            `I2CP_PAGE_P8:   b = 4'h3;
            `I2CP_PAGE_P9:   b = 4'h4;
            `I2CP_PAGE_P12:  b = 4'h5;
            `I2CP_PAGE_P13:  b = 4'h6;
            default:         b = 4'hF;
        endcase
        return b;
    endfunction

    // [R17] pages of 128 registers
    // [R22] eight bits, bit 7 most significant
    i2cp_byte_type mem [BANKS*REGS];

    wire logic [3:0] wr_bank  = bank_of(wr_page);
    wire logic [3:0] rd_bank  = bank_of(rd_page);
    wire logic       wr_hit   = (wr_bank != 4'hF);
    wire logic       rd_hit   = (rd_bank != 4'hF);
    wire logic [9:0] wr_index = {wr_bank[2:0], wr_reg};
    wire logic [9:0] rd_index = {rd_bank[2:0], rd_reg};

    // [R16] stored value reads back
    assign rd_data = rd_hit ? mem[rd_index] : 8'h00;

    always_ff @(posedge clk) begin
        if (wr_en && wr_hit) begin
            mem[wr_index] <= wr_data;
        end
    end

    // ----------------------------------------------------------------
    // write event held stable for the core side
    // ----------------------------------------------------------------
    logic             wr_tgl_r;
    i2cp_byte_type    wr_page_r;
    i2cp_reg_idx_type wr_reg_r;
    i2cp_byte_type    wr_data_r;

    // fields settle long before the toggle is seen on ref_clk
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_tgl_r  <= 1'b0;
            wr_page_r <= 8'h00;
            wr_reg_r  <= 7'h00;
            wr_data_r <= 8'h00;
        end else if (evt_en) begin
            wr_tgl_r  <= ~wr_tgl_r;
            wr_page_r <= wr_page;
            wr_reg_r  <= wr_reg;
            wr_data_r <= wr_data;
        end
    end

    // ----------------------------------------------------------------
    // core clock side
    // ----------------------------------------------------------------
    logic [2:0]       wr_sync_r;
    logic [1:0]       gc_sync_r;
    logic             cfg_wr_stb_r;
    i2cp_byte_type    cfg_page_r;
    i2cp_reg_idx_type cfg_reg_r;
    i2cp_byte_type    cfg_data_r;

    wire logic wr_evt = wr_sync_r[2] ^ wr_sync_r[1];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_sync_r <= 3'h0;
            gc_sync_r <= 2'h0;
        end else begin
            wr_sync_r <= {wr_sync_r[1:0], wr_tgl_r};
            gc_sync_r <= {gc_sync_r[0], gc_en};
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_wr_stb_r <= 1'b0;
            cfg_page_r   <= 8'h00;
            cfg_reg_r    <= 7'h00;
            cfg_data_r   <= 8'h00;
        end else begin
            cfg_wr_stb_r <= wr_evt;
            if (wr_evt) begin
                cfg_page_r <= wr_page_r;
                cfg_reg_r  <= wr_reg_r;
                cfg_data_r <= wr_data_r;
            end
        end
    end

    assign cfg_wr_stb = cfg_wr_stb_r;
    assign cfg_page   = cfg_page_r;
    assign cfg_reg    = cfg_reg_r;
    assign cfg_data   = cfg_data_r;
    assign gc_enable  = gc_sync_r[1];

    chk_cfg_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R16]
        cfg_wr_stb |=> !cfg_wr_stb ##1 !cfg_wr_stb)
        else $error("write strobe longer than one cycle");

endmodule // i2cp_regfile

// ===== tb/i2cp_master.sv
// i2cp_master: behavioural two-wire bus master for the slave bench.
// assumes the bench resolves the data line with a pull-up.
`timescale 1ns/1ps

module i2cp_master (
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda
);

    // ------------------------------------------------------------
    // quarter steps of an 80 ns link clock
    // ------------------------------------------------------------
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic step(input logic c, input logic l);
        scl = c;
        sda_low = l;
        #20;
    endtask

    task automatic start();
        #7;
        step(1'b0, sda_low);
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask

    task automatic stop();
        step(1'b0, sda_low);
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
    endtask

    // set with clock low, read with clock high
    task automatic bit_x(input logic b, output logic r);
        step(1'b0, sda_low);
        step(1'b0, !b);
        step(1'b1, !b);
        r = sda;
        step(1'b1, !b);
    endtask

    // eight bits msb first, then ack slot
    task automatic xbyte(input logic [7:0] d, input logic a,
                         output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], q[i]);
        end
        bit_x(a, ack);
    endtask

endmodule // i2cp_master

// ===== tb/i2cp_slave_bench.sv
// i2cp_slave_bench: self-checking bench of the paged two-wire slave.
// assumes i2cp_master as bus master and the design sources.
`timescale 1ns/1ps

module i2cp_slave_bench;
    import i2cp_pkg::*;

    logic             ref_clk, rst_n, scl, sda_low, sda;
    logic             sda_out, sda_oe, cfg_wr_stb, gc_enable;
    i2cp_byte_type    stat_flags, cfg_page, cfg_data;
    i2cp_reg_idx_type cfg_reg;
    int               err_total, checks_done;
    logic [22:0]      stb_q[$];
    logic [7:0]       q0, q1;

    assign sda = (sda_oe ? sda_out : 1'b1) & !sda_low;

    i2cp_master mst (.scl(scl), .sda_low(sda_low), .sda(sda));
    i2cp_slave dut (.ref_clk(ref_clk), .rst_n(rst_n), .scl(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .stat_flags(stat_flags),
        .cfg_wr_stb(cfg_wr_stb), .cfg_page(cfg_page), .cfg_reg(cfg_reg),
        .cfg_data(cfg_data), .gc_enable(gc_enable));

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        if (cfg_wr_stb === 1'b1) begin
            stb_q.push_back({cfg_page, cfg_reg, cfg_data});
        end
    end

    // ------------------------------------------------------------
    // compare and transfer helpers
    // ------------------------------------------------------------
    task automatic cmp8(input logic [7:0] g, input logic [7:0] e, input string m);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("unexpected at %0t: %s got %h expected %h", $time, m, g, e);
        end
    endtask

    task automatic cmp1(input logic g, input logic e, input string m);
        cmp8({7'h00, g}, {7'h00, e}, m);
    endtask

    task automatic wb(input logic [7:0] d, input logic exp_ack);
        logic [7:0] q;
        logic       a;
        mst.xbyte(d, 1'b1, q, a);
        cmp8(q, d, "line echo");
        cmp1(a, exp_ack, "ack slot");
    endtask

    task automatic wr(input logic [7:0] p, input logic [7:0] d0, input logic [7:0] d1,
                      input int n);
        mst.start();
        wb(8'h30, 1'b0);
        wb(p, 1'b0);
        wb(d0, 1'b0);
        if (n > 1) begin
            wb(d1, 1'b0);
        end
        mst.stop();
        repeat (8) @(posedge ref_clk);
    endtask

    task automatic rd(input logic [7:0] p, input int n,
                      output logic [7:0] r0, output logic [7:0] r1);
        logic a;
        mst.start();
        wb(8'h30, 1'b0);
        wb(p, 1'b0);
        mst.start();
        wb(8'h31, 1'b0);
        mst.xbyte(8'hFF, n == 1, r0, a);
        if (n > 1) begin
            mst.xbyte(8'hFF, 1'b1, r1, a);
        end
        mst.stop();
        repeat (4) @(posedge ref_clk);
    endtask

    task automatic chk_stb(input logic [7:0] p, input logic [6:0] r, input logic [7:0] d);
        logic [22:0] e;
        for (int i = 0; i < 20 && stb_q.size() == 0; i++) begin
            @(posedge ref_clk);
        end
        if (stb_q.size() == 0) begin
            err_total++;
            $display("unexpected at %0t: write strobe missing", $time);
            results();
        end
        e = stb_q.pop_front();
        cmp8(e[22:15], p, "strobe page");
        cmp8({1'b0, e[14:8]}, {1'b0, r}, "strobe reg");
        cmp8(e[7:0], d, "strobe data");
    endtask

    task automatic wait_gc(input logic v);
        for (int i = 0; i < 20 && gc_enable !== v; i++) begin
            @(posedge ref_clk);
        end
        cmp1(gc_enable, v, "gc enable");
        if (gc_enable !== v) begin
            results();
        end
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_incr();
        cmp1(sda_oe, 1'b0, "idle drive");
        rd(8'h00, 1, q0, q1);
        cmp8(q0, 8'h00, "reset page");
        wr(8'h10, 8'hA5, 8'h3C, 2);
        chk_stb(8'h00, 7'h10, 8'hA5);
        chk_stb(8'h00, 7'h11, 8'h3C);
        rd(8'h10, 2, q0, q1);
        cmp8(q0, 8'hA5, "read first");
        cmp8(q1, 8'h3C, "read next");
        wr(8'h7F, 8'h5E, 8'h00, 2);
        chk_stb(8'h00, 7'h7F, 8'h5E);
        chk_stb(8'h00, 7'h00, 8'h00);
        $display("test auto increment done");
    endtask

    task automatic t_addr();
        logic [7:0] bad [3] = '{8'h32, 8'hB0, 8'h00};
        for (int i = 0; i < 3; i++) begin
            mst.start();
            wb(bad[i], 1'b1);
            wb(8'h55, 1'b1);
            mst.stop();
        end
        wr(8'h22, 8'h20, 8'h00, 1);
        chk_stb(8'h00, 7'h22, 8'h20);
        wait_gc(1'b1);
        mst.start();
        wb(8'h00, 1'b0);
        mst.stop();
        wr(8'h22, 8'h00, 8'h00, 1);
        chk_stb(8'h00, 7'h22, 8'h00);
        wait_gc(1'b0);
        $display("test addressing done");
    endtask

    task automatic t_page();
        wr(8'h00, 8'h01, 8'h00, 1);
        chk_stb(8'h00, 7'h00, 8'h01);
        wr(8'h10, 8'h77, 8'h00, 1);
        chk_stb(8'h01, 7'h10, 8'h77);
        rd(8'h00, 1, q0, q1);
        cmp8(q0, 8'h01, "page readback");
        rd(8'h10, 1, q0, q1);
        cmp8(q0, 8'h77, "page one data");
        wr(8'h00, 8'h00, 8'h00, 1);
        chk_stb(8'h01, 7'h00, 8'h00);
        rd(8'h10, 1, q0, q1);
        cmp8(q0, 8'hA5, "page zero kept");
        $display("test paging done");
    endtask

    task automatic t_status();
        @(posedge ref_clk);
        stat_flags <= 8'h5A;
        repeat (4) @(posedge ref_clk);
        rd(8'h03, 1, q0, q1);
        cmp8(q0, 8'h5A, "status read");
        wr(8'h03, 8'h00, 8'h00, 1);
        chk_stb(8'h00, 7'h03, 8'h00);
        rd(8'h03, 1, q0, q1);
        cmp8(q0, 8'h5A, "status kept");
        $display("test status done");
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        rst_n = 1'b0;
        stat_flags = 8'h00;
        err_total = 0;
        checks_done = 0;
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        t_incr();
        t_addr();
        t_page();
        t_status();
        results();
    end

endmodule // i2cp_slave_bench
